// >>> common/lcg_defs.vh
// register map, field positions and sizes for the logic cell gate input stage
`ifndef LCG_DEFS_VH
`define LCG_DEFS_VH

// register byte offsets on the apb bus
`define LCG_OFF_GATE0_SEL   12'h000
`define LCG_OFF_GATE1_SEL   12'h004
`define LCG_OFF_GATE2_SEL   12'h008
`define LCG_OFF_DATA_SRC    12'h00C
`define LCG_OFF_GATE_POL    12'h010
`define LCG_OFF_STATUS      12'h014

// gate select register fields
`define LCG_D4_TRUE         7
`define LCG_D4_INV          6
`define LCG_D3_TRUE         5
`define LCG_D3_INV          4
`define LCG_D2_TRUE         3
`define LCG_D2_INV          2
`define LCG_D1_TRUE         1
`define LCG_D1_INV          0

// data source select: four 5-bit fields packed at bytes 0..3
`define LCG_SRC_W           5
`define LCG_NUM_SRC         32
`define LCG_GSEL_W          8

// reset values for the bus-side control state; only the polarity one is used, selects and sources have no reset
`define LCG_RST_GSEL        8'h00
`define LCG_RST_SRC         5'h00
`define LCG_RST_POL         3'h0

`endif

// >>> src/lcg_gate.v
// one and-or gate: or of the selected true and inverted data terms
`timescale 1ns/1ps
`include "lcg_defs.vh"

module lcg_gate (
   input  wire [7:0] sel,
   input  wire [3:0] data,
   input  wire       invert,
   output wire       gate_out
);

   wire [7:0] terms;
   wire       gate_or;

   assign terms[`LCG_D4_TRUE] = sel[`LCG_D4_TRUE] & data[3];
   assign terms[`LCG_D4_INV]  = sel[`LCG_D4_INV]  & ~data[3];
   assign terms[`LCG_D3_TRUE] = sel[`LCG_D3_TRUE] & data[2];
   assign terms[`LCG_D3_INV]  = sel[`LCG_D3_INV]  & ~data[2];
   assign terms[`LCG_D2_TRUE] = sel[`LCG_D2_TRUE] & data[1];
   assign terms[`LCG_D2_INV]  = sel[`LCG_D2_INV]  & ~data[1];
   assign terms[`LCG_D1_TRUE] = sel[`LCG_D1_TRUE] & data[0];
   assign terms[`LCG_D1_INV]  = sel[`LCG_D1_INV]  & ~data[0];

   // or of selected terms, zero when none
   assign gate_or = |terms;

   assign gate_out = gate_or ^ invert;

endmodule

// >>> src/lcg_top.v
// logic cell gate input stage: apb registers, data source muxes, gates 0 to 2
// Function
// - gate0 select bits 7..4: data four and three, true and inverted
// - gate0 select bits 3..0: data two and one, true and inverted
// - gate1 select bits 7..4: data four and three, true and inverted
// - gate1 select bits 3..0: data two and one, true and inverted
// - gate2 select bits 7..4: data four and three, true and inverted
// - gate2 select bits 3..0: data two and one, true and inverted
// - cleared bit excludes its term; true and inverted act independently
// - select bits read/write; undefined after power reset, kept by others
// - each data input picked by its own 5-bit source field
// - each gate output inverted when its polarity bit is set
`timescale 1ns/1ps
`include "lcg_defs.vh"

module lcg_top (
   input  wire        clk,
   input  wire        reset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire [31:0] src_signals,
   output wire [2:0]  gate_out,
   output reg  [3:0]  selected_data_q
);

   reg  [7:0] gate0_input_select_q;
   reg  [7:0] gate1_input_select_q;
   reg  [7:0] gate2_input_select_q;
   reg  [4:0] data_one_source_sel_q;
   reg  [4:0] data_two_source_sel_q;
   reg  [4:0] data_three_source_sel_q;
   reg  [4:0] data_four_source_sel_q;
   reg  [2:0] gate_invert_q;
   reg  [31:0] rdata_d;
   reg        addr_ok;
   wire       wr_en;
   wire       selected_data_one;
   wire       selected_data_two;
   wire       selected_data_three;
   wire       selected_data_four;
   wire [3:0] data_bus;
   wire       acc_phase;
   wire       rd_setup;
   wire       hit_gate0;
   wire       hit_gate1;
   wire       hit_gate2;
   wire       hit_src;
   wire       hit_pol;
   wire       lane0_wr;
   wire       lane1_wr;
   wire       lane2_wr;
   wire       lane3_wr;
   wire       gate0_wr;
   wire       gate1_wr;
   wire       gate2_wr;
   wire       pol_wr;
   wire [31:0] rd_gate0;
   wire [31:0] rd_gate1;
   wire [31:0] rd_gate2;
   wire [31:0] rd_src;
   wire [31:0] rd_pol;
   wire [31:0] rd_stat;

   // register map, one aligned 32-bit word per register:
   //   0x000 gate 0 select
   //   0x004 gate 1 select
   //   0x008 gate 2 select
   //   0x00C source fields: 4:0 one, 12:8 two, 20:16 three, 28:24 four
   //   0x010 gate polarity bits 2:0, one per gate
   //   0x014 status, read only: gate results 6:4, selected data 3:0
   // select words: bit 7 data four true down to bit 0 data one inverted
   // all other offsets, unaligned ones included, answer with pslverr
   //
   // limitations a user must know:
   //   select and source words have no reset, so write them before
   //   trusting gate_out; a block reset will not clear a stale routing
   //   status gate bits are live values taken at the read setup edge,
   //   so a change inside the access phase shows on the next read
   //   the source mux is a plain index, any of the 32 sources is legal
   //   writes to the status word are accepted and dropped, no error
   //
   // trade-off: read data is registered at setup, which costs one flop
   // word but keeps prdata steady for the whole access phase

   // transfer phase qualifiers
   assign acc_phase = psel & penable;
   assign rd_setup  = psel & ~penable & ~pwrite;

   // word hits compare the whole address so unaligned offsets miss
   assign hit_gate0 = (paddr == `LCG_OFF_GATE0_SEL);
   assign hit_gate1 = (paddr == `LCG_OFF_GATE1_SEL);
   assign hit_gate2 = (paddr == `LCG_OFF_GATE2_SEL);
   assign hit_src   = (paddr == `LCG_OFF_DATA_SRC);
   assign hit_pol   = (paddr == `LCG_OFF_GATE_POL);

   // byte lane strobes, only for a mapped word in the access phase
   assign lane0_wr = wr_en & pstrb[0];
   assign lane1_wr = wr_en & pstrb[1];
   assign lane2_wr = wr_en & pstrb[2];
   assign lane3_wr = wr_en & pstrb[3];

   // per-register write enables; 8-bit words need lane 0
   assign gate0_wr = lane0_wr & hit_gate0;
   assign gate1_wr = lane0_wr & hit_gate1;
   assign gate2_wr = lane0_wr & hit_gate2;
   assign pol_wr   = lane0_wr & hit_pol;

   // read words, unused upper bits read as zero
   assign rd_gate0 = {24'h000000, gate0_input_select_q};
   assign rd_gate1 = {24'h000000, gate1_input_select_q};
   assign rd_gate2 = {24'h000000, gate2_input_select_q};
   assign rd_src   = {3'h0, data_four_source_sel_q, 3'h0, data_three_source_sel_q,
                      3'h0, data_two_source_sel_q, 3'h0, data_one_source_sel_q};
   assign rd_pol   = {29'h0, gate_invert_q};
   assign rd_stat  = {25'h0, gate_out, selected_data_q};

   // zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_en   = acc_phase & pwrite & addr_ok;
   assign pslverr = acc_phase & ~addr_ok;

   // address decode, unmapped offsets answer with pslverr and read zero
   always @* begin
      addr_ok = 1'b0;
      rdata_d = 32'h00000000;
      case (paddr)
         `LCG_OFF_GATE0_SEL: begin
            addr_ok = 1'b1;
            rdata_d = rd_gate0;
         end
         `LCG_OFF_GATE1_SEL: begin
            addr_ok = 1'b1;
            rdata_d = rd_gate1;
         end
         `LCG_OFF_GATE2_SEL: begin
            addr_ok = 1'b1;
            rdata_d = rd_gate2;
         end
         `LCG_OFF_DATA_SRC: begin
            addr_ok = 1'b1;
            rdata_d = rd_src;
         end
         `LCG_OFF_GATE_POL: begin
            addr_ok = 1'b1;
            rdata_d = rd_pol;
         end
         `LCG_OFF_STATUS: begin
            addr_ok = 1'b1;
            rdata_d = rd_stat;
         end
         default: begin
            addr_ok = 1'b0;
            rdata_d = 32'h00000000;
         end
      endcase
   end

   // read data registered in setup so it is valid throughout the access phase
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= rdata_d;
      end
   end

   // gate 0 select: no reset branch, so power-up value is unknown
   // and the block reset leaves it untouched
   always @(posedge clk) begin
      if (gate0_wr) begin
         gate0_input_select_q <= pwdata[7:0];
      end
   end

   // gate 1 select, kept over block reset
   always @(posedge clk) begin
      if (gate1_wr) begin
         gate1_input_select_q <= pwdata[7:0];
      end
   end

   // gate 2 select, kept over block reset
   always @(posedge clk) begin
      if (gate2_wr) begin
         gate2_input_select_q <= pwdata[7:0];
      end
   end

   // data one source field, byte lane 0; kept over block reset
   always @(posedge clk) begin
      if (lane0_wr & hit_src) begin
         data_one_source_sel_q <= pwdata[4:0];
      end
   end

   // data two source field, byte lane 1
   always @(posedge clk) begin
      if (lane1_wr & hit_src) begin
         data_two_source_sel_q <= pwdata[12:8];
      end
   end

   // data three source field, byte lane 2
   always @(posedge clk) begin
      if (lane2_wr & hit_src) begin
         data_three_source_sel_q <= pwdata[20:16];
      end
   end

   // data four source field, byte lane 3
   always @(posedge clk) begin
      if (lane3_wr & hit_src) begin
         data_four_source_sel_q <= pwdata[28:24];
      end
   end

   // polarity bits reset to non-inverted
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         gate_invert_q <= `LCG_RST_POL;
      end else if (pol_wr) begin
         gate_invert_q <= pwdata[2:0];
      end
   end

   assign selected_data_one   = src_signals[data_one_source_sel_q];
   assign selected_data_two   = src_signals[data_two_source_sel_q];
   assign selected_data_three = src_signals[data_three_source_sel_q];
   assign selected_data_four  = src_signals[data_four_source_sel_q];
   assign data_bus = {selected_data_four, selected_data_three,
                      selected_data_two, selected_data_one};

   // sampled copy of the selected data for the status register
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         selected_data_q <= 4'h0;
      end else begin
         selected_data_q <= data_bus;
      end
   end

   // each gate ors its selected true and inverted terms, then applies
   // its own polarity bit; the three gates share one data bus so a
   // source change reaches all of them in the same cycle
   // gate results are combinational: the far side must register them
   // if it needs a glitch-free value

   lcg_gate u_gate0 (
      .sel      (gate0_input_select_q),
      .data     (data_bus),
      .invert   (gate_invert_q[0]),
      .gate_out (gate_out[0])
   );

   lcg_gate u_gate1 (
      .sel      (gate1_input_select_q),
      .data     (data_bus),
      .invert   (gate_invert_q[1]),
      .gate_out (gate_out[1])
   );

   lcg_gate u_gate2 (
      .sel      (gate2_input_select_q),
      .data     (data_bus),
      .invert   (gate_invert_q[2]),
      .gate_out (gate_out[2])
   );

endmodule

// >>> test/lcg_top_assertions.sv
// port checker for the gate input stage
`timescale 1ns/1ps
module lcg_chk (
   input logic        clk,
   input logic        reset,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic        pready,
   input logic [31:0] prdata,
   input logic        pslverr,
   input logic [2:0]  gate_out,
   input logic [3:0]  selected_data_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // read setup cycle and unmapped decode
   wire rs = psel && !penable && !pwrite;
   wire um = paddr > 12'h014 || paddr[1:0] != 2'b00;
   rdy_const_a: assert property (pready)
      else $error("pready low");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   err_unmap_a: assert property (psel && penable && um |-> pslverr)
      else $error("unmapped not refused");
   err_mapped_a: assert property (psel && penable && !um |-> !pslverr)
      else $error("mapped refused");
   rd_hold_a: assert property (!rs |=> $stable(prdata))
      else $error("prdata moved");
   rd_unmap_a: assert property (rs && um |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   rd_width_a: assert property (rs && paddr <= 12'h008 |=> prdata[31:8] == 24'h0)
      else $error("select upper bits set");
   stat_live_a: assert property (rs && paddr == 12'h014 |=>
      prdata == {25'h0, $past(gate_out), $past(selected_data_q)})
      else $error("status mismatch");
   data_rst_a: assert property ($fell(reset) |-> selected_data_q == 4'h0)
      else $error("data not cleared");
endmodule

bind lcg_top lcg_chk u_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pready,
   .prdata, .pslverr, .gate_out, .selected_data_q);

// >>> test/lcg_src_model.sv
// far-side model: source signals feeding the data selectors
`timescale 1ns/1ps
module lcg_src_model (
   input  logic        clk,
   input  logic [31:0] pattern,
   output logic [31:0] src_signals
);
   // sources move only after an edge, like synchronous upstream logic
   always @(posedge clk) begin
      src_signals <= pattern;
   end
endmodule

// >>> test/lcg_top_tb_top.sv
// self-checking bench for the gate input stage
`timescale 1ns/1ps
`include "lcg_defs.vh"
module lcg_top_tb_top;
   logic        clk = 0;
   logic        reset = 1;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] pattern = 32'h0;
   wire         pready;
   wire         pslverr;
   wire  [31:0] prdata;
   wire  [31:0] src_signals;
   wire  [2:0]  gate_out;
   wire  [3:0]  selected_data_q;
   logic [32:0] exp_q[$];
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          seed = 11707;
   int          cycles = 0;
   logic [7:0]  sel [3];
   logic [4:0]  fld [4];
   logic [2:0]  pol;
   logic [3:0]  d;
   logic [2:0]  g;
   lcg_top u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .prdata, .pslverr, .src_signals, .gate_out, .selected_data_q);
   lcg_src_model u_src (.clk, .pattern, .src_signals);
   initial forever #2 clk = ~clk;
   task end_of_test();
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task check(input string nm, input logic [32:0] seen, input logic [32:0] want);
      samples_checked++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, want, seen);
      end
   endtask
   // one apb transfer; an idle edge follows so strobes never double up
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // watcher: each completed read takes the oldest note
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (psel && penable && pready && !pwrite)
         check("read", {pslverr, prdata}, exp_q.pop_front());
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // random routing; status holds the live gate results
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         for (int k = 0; k < 4; k++) fld[k] = 5'($random(seed));
         for (int k = 0; k < 3; k++) sel[k] = 8'($random(seed));
         if (i == 0) sel = '{8'h00, 8'hFF, 8'hC0};
         pol = 3'($random(seed));
         pattern <= $random(seed);
         for (int k = 0; k < 3; k++) apb(1'b1, 12'(4 * k), {24'h0, sel[k]});
         apb(1'b1, `LCG_OFF_DATA_SRC, {3'h0, fld[3], 3'h0, fld[2], 3'h0, fld[1], 3'h0, fld[0]});
         apb(1'b1, `LCG_OFF_GATE_POL, {29'h0, pol});
         for (int k = 0; k < 4; k++) d[k] = pattern[fld[k]];
         for (int k = 0; k < 3; k++)
            g[k] = pol[k] ^ |(sel[k] & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
         for (int k = 0; k < 3; k++) rd(12'(4 * k), {25'h0, sel[k]});
         rd(`LCG_OFF_STATUS, {26'h0, g, d});
         check("gate", {30'h0, gate_out}, {30'h0, g});
         check("data", {29'h0, selected_data_q}, {29'h0, d});
      end
      rd(12'h020, {1'b1, 32'h0});
      pstrb <= 4'h0;
      apb(1'b1, 12'h000, 32'h0000005A);
      pstrb <= 4'hF;
      rd(12'h000, {25'h0, sel[0]});
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 3; k++) rd(12'(4 * k), {25'h0, sel[k]});
      rd(`LCG_OFF_GATE_POL, 33'h0);
      end_of_test();
   end
endmodule
